//--- verif/tb_timer_event_irq_control.sv
// Purpose: self-checking bench for the timer event and irq-enable control slice
// Assumes: ce held high, so every apb access completes without wait states
// Notes: random traffic from seed 79, then fixed corner cases after it
`default_nettype none
module tb_timer_event_irq_control import timer_event_irq_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, err, dbg = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, r;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, timerRun, wrapEventOut, irqRequest;
  logic timerEnabled = 0, writeProtect = 0, softReset = 0, debugHalt = 0, wrapHit = 0, eventIn = 0;
  logic [1:0] channelHit = '0, waveformRaw = '0, captureSelect, waveformOutputPin, channelEventOut;
  logic [7:0] irqFlags = '0, chm = '0, irqm = '0;
  logic [15:0] ev = '0;
  logic [7:0] idxList [5] = '{IDX_CHMODE, IDX_DEBUG, IDX_EVENT_CONTROL, IDX_IRQCLR, IDX_IRQSET};
  evaction_type evAction;
  int fail_count = 0, num_checks = 0, k;

  always #25 clk = ~clk;

  timer_event_irq_control DUT (.clk(clk), .resetn(resetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .timerEnabled(timerEnabled), .writeProtect(writeProtect), .softReset(softReset),
    .debugHalt(debugHalt), .channelHit(channelHit), .wrapHit(wrapHit), .irqFlags(irqFlags),
    .waveformRaw(waveformRaw), .eventIn(eventIn), .captureSelect(captureSelect), .timerRun(timerRun),
    .evAction(evAction), .waveformOutputPin(waveformOutputPin), .channelEventOut(channelEventOut),
    .wrapEventOut(wrapEventOut), .irqRequest(irqRequest));

  task stop_test;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one transfer; release happens at the edge where pready is seen
  task apb(input logic wrt, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wrt;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    n = 0;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      fail_count++;
      stop_test;
    end
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1'b1, idx, wd);
    if (!writeProtect)
      case (idx)
        IDX_CHMODE: chm = wd[7:0] & 8'h33;
        IDX_DEBUG: dbg = wd[0];
        IDX_EVENT_CONTROL: ev = timerEnabled ? ((wd[15:0] & 16'h3130) | (ev & 16'h0007)) : (wd[15:0] & 16'h3137);
        IDX_IRQCLR: irqm = irqm & ~(wd[7:0] & IRQ_MASK_BITS);
        IDX_IRQSET: irqm = irqm | (wd[7:0] & IRQ_MASK_BITS);
        default: ;
      endcase
  endtask

  function automatic logic [31:0] rexp(input logic [7:0] idx);
    case (idx)
      IDX_CHMODE: return {24'h0, chm};
      IDX_DEBUG: return {31'h0, dbg};
      IDX_EVENT_CONTROL: return {16'h0, ev};
      IDX_IRQCLR, IDX_IRQSET: return {24'h0, irqm};
      default: return 32'h0;
    endcase
  endfunction

  task rdchk(input logic [7:0] idx);
    apb(1'b0, idx, 32'h0);
    check(rd, rexp(idx));
    check({31'h0, err}, {31'h0, !(idx inside {IDX_CHMODE, IDX_DEBUG, IDX_EVENT_CONTROL, IDX_IRQCLR, IDX_IRQSET})});
  endtask

  function automatic evaction_type actExp(input logic [2:0] code, input logic en, inv, rise);
    evaction_type a;
    logic srcRise;
    a = '0;
    srcRise = rise ^ inv;
    if (en)
    begin
      a.retrigger = rise && code == ACT_RETRIG;
      a.countStep = rise && code == ACT_COUNT;
      a.startOnly = rise && code == ACT_START;
      if (code == ACT_PPW)
      begin
        a.periodCapture = {1'b0, srcRise};
        a.widthCapture = {!srcRise, 1'b0};
      end
      if (code == ACT_PWP)
      begin
        a.periodCapture = {srcRise, 1'b0};
        a.widthCapture = {1'b0, !srcRise};
      end
    end
    return a;
  endfunction

  initial
  begin
    r = $urandom(79);
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    foreach (idxList[i]) rdchk(idxList[i]);
    rdchk(8'h07);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge clk);
      r = $urandom;
      k = int'(r[15:11]) % 5;
      irqFlags <= r[7:0];
      waveformRaw <= r[9:8];
      timerEnabled <= r[10] && k != 1;
      wr(idxList[k], $urandom);
      rdchk(idxList[$urandom % 5]);
      @(negedge clk);
      check({31'h0, irqRequest}, {31'h0, |(irqFlags & irqm)});
      check({30'h0, captureSelect}, {30'h0, chm[5:4]});
      check({30'h0, waveformOutputPin}, {30'h0, waveformRaw ^ chm[1:0]});
    end
    @(posedge clk);
    timerEnabled <= 1'b0;
    wr(IDX_IRQCLR, 32'hff);
    wr(IDX_IRQSET, 32'h02);
    rdchk(IDX_IRQCLR);
    wr(IDX_IRQSET, 32'h31);
    wr(IDX_IRQCLR, 32'h02);
    rdchk(IDX_IRQSET);
    @(posedge clk);
    writeProtect <= 1'b1;
    foreach (idxList[i]) wr(idxList[i], 32'hffffffff);
    @(posedge clk);
    writeProtect <= 1'b0;
    foreach (idxList[i]) rdchk(idxList[i]);
    wr(IDX_DEBUG, 32'h1);
    wr(IDX_CHMODE, 32'h33);
    wr(IDX_IRQSET, 32'h3b);
    wr(IDX_EVENT_CONTROL, 32'h3137);
    @(posedge clk);
    softReset <= 1'b1;
    @(posedge clk);
    softReset <= 1'b0;
    chm = '0;
    ev = '0;
    irqm = '0;
    foreach (idxList[i]) rdchk(idxList[i]);
    for (int d = 0; d < 2; d++)
    begin
      wr(IDX_DEBUG, d);
      @(posedge clk);
      debugHalt <= 1'b1;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({31'h0, timerRun}, d);
      @(posedge clk);
      debugHalt <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check({31'h0, timerRun}, 32'h1);
    end
    for (int i = 0; i < 6; i++)
    begin
      r = $urandom;
      wr(IDX_EVENT_CONTROL, {18'h0, r[1:0], 3'h0, r[2], 8'h00});
      @(posedge clk);
      channelHit <= 2'b11;
      wrapHit <= 1'b1;
      @(posedge clk);
      channelHit <= 2'b00;
      wrapHit <= 1'b0;
      @(negedge clk);
      check({29'h0, channelEventOut, wrapEventOut}, {29'h0, r[1:0], r[2]});
      @(negedge clk);
      check({29'h0, channelEventOut, wrapEventOut}, 32'h0);
    end
    // every action code, with input enable and invert both ways
    for (int c = 0; c < 32; c++)
    begin
      wr(IDX_EVENT_CONTROL, {26'h0, c[4], c[3], 1'b0, c[2:0]});
      for (int e = 0; e < 2; e++)
      begin
        @(posedge clk);
        eventIn <= (e == 0);
        @(posedge clk);
        @(negedge clk);
        check({25'h0, evAction}, {25'h0, actExp(c[2:0], c[4], c[3], e == 0)});
      end
    end
    stop_test;
  end
endmodule
`default_nettype wire

//--- verilog/timer_event_irq_control.sv
// Purpose: channel mode, debug, event and irq-enable registers of a 16-bit timer
// Assumes: counting engine, flags and sync logic sit outside on the same clock
// Notes: APB4 slave, zero wait states, registered read data
//
// Added by the designer: the APB register port.
`default_nettype none
module timer_event_irq_control
  import timer_event_irq_pkg::*;
#(
  parameter int CHANNELS = 2
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // timer status from the counting engine
  input wire logic timerEnabled,
  input wire logic writeProtect,
  input wire logic softReset,
  input wire logic debugHalt,
  // hits and flags from the counting engine
  input wire logic [CHANNELS-1:0] channelHit,
  input wire logic wrapHit,
  input wire logic [7:0] irqFlags,
  input wire logic [CHANNELS-1:0] waveformRaw,
  // incoming event
  input wire logic eventIn,
  // to the counting engine
  output logic [CHANNELS-1:0] captureSelect,
  output logic timerRun,
  output evaction_type evAction,
  // pins and event outputs
  output logic [CHANNELS-1:0] waveformOutputPin,
  output logic [CHANNELS-1:0] channelEventOut,
  output logic wrapEventOut,
  output logic irqRequest
);

  function automatic logic hitIdx(input logic [APB_AW-1:0] a, input logic [7:0] i);
    hitIdx = (a[APB_AW-1:2] == {{(APB_AW-10){1'b0}}, i});
  endfunction

  function automatic logic [15:0] evImage(input event_control_type e);
    logic [15:0] v;
    v = 16'h0000;
    v[CHEO_LSB +: 2] = e.chanEo;
    v[WRAPEO_BIT] = e.wrapEo;
    v[EVIN_EN_BIT] = e.inEnable;
    v[EVIN_INV_BIT] = e.inInvert;
    v[EVENT_ACTION_LSB +: 3] = e.action;
    evImage = v;
  endfunction

  // register state
  logic [1:0] capSel_q;
  logic [1:0] invSel_q;
  logic run_in_debug_halt_q;
  event_control_type ev_q;
  event_control_type ev_d;
  logic [7:0] irqEn_q;
  logic [7:0] irqEn_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // bus decode
  wire hitChMode = hitIdx(paddr, IDX_CHMODE);
  wire hitDebug = hitIdx(paddr, IDX_DEBUG);
  wire hitEv = hitIdx(paddr, IDX_EVENT_CONTROL);
  wire hitClr = hitIdx(paddr, IDX_IRQCLR);
  wire hitSet = hitIdx(paddr, IDX_IRQSET);
  wire mapped = hitChMode | hitDebug | hitEv | hitClr | hitSet;
  wire access = ce & psel & penable;
  wire wrAccess = access & pwrite & mapped;
  // protection drops the write but still completes the transfer
  wire wrOpen = wrAccess & ~writeProtect & ~softReset;
  wire wrChMode = wrOpen & hitChMode & pstrb[0];
  wire wrDebug = wrOpen & hitDebug & pstrb[0];
  wire wrEvLo = wrOpen & hitEv & pstrb[0];
  wire wrEvHi = wrOpen & hitEv & pstrb[1];
  wire wrClr = wrOpen & hitClr & pstrb[0];
  wire wrSet = wrOpen & hitSet & pstrb[0];
  wire [7:0] wrBits = pwdata[7:0] & IRQ_MASK_BITS;

  assign pready = ce;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = rdata_q;

  // event control next value; action frozen while timerEnabled is high
  always_comb
  begin
    ev_d = ev_q;
    if (wrEvHi)
    begin
      ev_d.chanEo = pwdata[CHEO_LSB +: 2];
      ev_d.wrapEo = pwdata[WRAPEO_BIT];
    end
    if (wrEvLo)
    begin
      ev_d.inEnable = pwdata[EVIN_EN_BIT];
      ev_d.inInvert = pwdata[EVIN_INV_BIT];
      if (!timerEnabled)
      begin
        ev_d.action = pwdata[EVENT_ACTION_LSB +: 3];
      end
    end
    if (softReset)
    begin
      ev_d = EVENT_CONTROL_RESET;
    end
  end

  // one shared mask behind both addresses
  always_comb
  begin
    irqEn_d = irqEn_q;
    if (wrClr)
    begin
      irqEn_d = irqEn_q & ~wrBits;
    end
    if (wrSet)
    begin
      irqEn_d = irqEn_q | wrBits;
    end
    if (softReset)
    begin
      irqEn_d = IRQEN_RESET;
    end
  end

  // read data is captured in the setup phase so prdata is a flop
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (hitChMode)
    begin
      rdata_d[CAPSEL_LSB +: 2] = capSel_q;
      rdata_d[INVSEL_LSB +: 2] = invSel_q;
    end
    if (hitDebug)
    begin
      rdata_d[RUN_IN_DEBUG_HALT_BIT] = run_in_debug_halt_q;
    end
    if (hitEv)
    begin
      rdata_d[15:0] = evImage(ev_q);
    end
    if (hitClr | hitSet)
    begin
      rdata_d[7:0] = irqEn_q;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_q <= 32'h0000_0000;
    end
    else if (ce && psel && !penable)
    begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      capSel_q <= CHMODE_RESET;
      invSel_q <= CHMODE_RESET;
    end
    else if (ce && softReset)
    begin
      capSel_q <= CHMODE_RESET;
      invSel_q <= CHMODE_RESET;
    end
    else if (wrChMode)
    begin
      capSel_q <= pwdata[CAPSEL_LSB +: 2];
      invSel_q <= pwdata[INVSEL_LSB +: 2];
    end
  end

  // debug run ignores the soft reset on purpose
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_in_debug_halt_q <= RUN_IN_DEBUG_HALT_RESET;
    end
    else if (wrDebug)
    begin
      run_in_debug_halt_q <= pwdata[RUN_IN_DEBUG_HALT_BIT];
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ev_q <= EVENT_CONTROL_RESET;
      irqEn_q <= IRQEN_RESET;
    end
    else if (ce)
    begin
      ev_q <= ev_d;
      irqEn_q <= irqEn_d;
    end
  end

  assign captureSelect = capSel_q;
  assign irqRequest = |(irqFlags & irqEn_q);

  // outputs toward pins and event system
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      waveformOutputPin <= '0;
      channelEventOut <= '0;
      wrapEventOut <= 1'b0;
      timerRun <= 1'b1;
    end
    else if (ce)
    begin
      waveformOutputPin <= waveformRaw ^ invSel_q;
      channelEventOut <= channelHit & ev_q.chanEo;
      wrapEventOut <= wrapHit & ev_q.wrapEo;
      timerRun <= ~(debugHalt & ~run_in_debug_halt_q);
    end
  end

  // incoming event handling
  logic evPrev_q;
  logic measPrev_q;
  wire measLevel = eventIn ^ ev_q.inInvert;
  wire evRise = eventIn & ~evPrev_q & ev_q.inEnable;
  wire measRise = measLevel & ~measPrev_q & ev_q.inEnable;
  wire measFall = ~measLevel & measPrev_q & ev_q.inEnable;
  wire isPpw = (ev_q.action == ACT_PPW);
  wire isPwp = (ev_q.action == ACT_PWP);
  evaction_type act_d;

  // reserved codes 4 and 7 behave as none
  always_comb
  begin
    act_d = '0;
    act_d.retrigger = evRise & (ev_q.action == ACT_RETRIG);
    act_d.countStep = evRise & (ev_q.action == ACT_COUNT);
    act_d.startOnly = evRise & (ev_q.action == ACT_START);
    act_d.periodCapture = {measRise & isPwp, measRise & isPpw};
    act_d.widthCapture = {measFall & isPpw, measFall & isPwp};
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      evPrev_q <= 1'b0;
      measPrev_q <= 1'b0;
      evAction <= '0;
    end
    else if (ce)
    begin
      evPrev_q <= eventIn;
      measPrev_q <= measLevel;
      evAction <= act_d;
    end
  end

  // checks
  // a soft reset may legally clear the action field, so it is left out
  sequence s_evWrite;
    ce && psel && penable && pwrite && hitEv && pstrb[0] && !softReset;
  endsequence

  sequence s_setWrite;
    wrSet;
  endsequence

  property p_resvRead;
    @(posedge clk) disable iff (!resetn)
    (ce && psel && !penable && hitDebug) |=> (prdata[31:1] == 31'h0);
  endproperty
  a_resvRead: assert property (p_resvRead) else $error("reserved bits nonzero");

  property p_dbgKeep;
    @(posedge clk) disable iff (!resetn)
    (ce && softReset) |=> (run_in_debug_halt_q == $past(run_in_debug_halt_q));
  endproperty
  a_dbgKeep: assert property (p_dbgKeep) else $error("debug run lost on soft reset");

  property p_halt;
    @(posedge clk) disable iff (!resetn)
    (ce && debugHalt && !run_in_debug_halt_q) |=> !timerRun;
  endproperty
  a_halt: assert property (p_halt) else $error("timer ran in debug halt");

  property p_chanEvent;
    @(posedge clk) disable iff (!resetn)
    ce |=> (channelEventOut == $past(channelHit & ev_q.chanEo));
  endproperty
  a_chanEvent: assert property (p_chanEvent) else $error("channel event mismatch");

  property p_wrapEvent;
    @(posedge clk) disable iff (!resetn)
    (ce && wrapHit && !ev_q.wrapEo) |=> !wrapEventOut;
  endproperty
  a_wrapEvent: assert property (p_wrapEvent) else $error("wrap event while disabled");

  property p_actionLocked;
    @(posedge clk) disable iff (!resetn)
    (s_evWrite and timerEnabled) |=> $stable(ev_q.action);
  endproperty
  a_actionLocked: assert property (p_actionLocked) else $error("action changed while enabled");

  property p_inputGate;
    @(posedge clk) disable iff (!resetn)
    (ce && !ev_q.inEnable) |=> (evAction == '0);
  endproperty
  a_inputGate: assert property (p_inputGate) else $error("event acted while disabled");

  property p_ppw;
    @(posedge clk) disable iff (!resetn)
    (ce && ev_q.inEnable && isPpw && measLevel && !measPrev_q) |=> (evAction.periodCapture == 2'b01);
  endproperty
  a_ppw: assert property (p_ppw) else $error("period capture wrong channel");

  property p_maskSet;
    @(posedge clk) disable iff (!resetn)
    s_setWrite |=> ((irqEn_q & $past(wrBits)) == $past(wrBits));
  endproperty
  a_maskSet: assert property (p_maskSet) else $error("enable not set");

  property p_irq;
    @(posedge clk) disable iff (!resetn)
    (irqFlags[1] && irqEn_q[1]) |-> irqRequest;
  endproperty
  a_irq: assert property (p_irq) else $error("missing irq request");

  property p_protect;
    @(posedge clk) disable iff (!resetn)
    (ce && writeProtect && !softReset && psel && penable && pwrite) |=> ($stable(irqEn_q) && $stable(run_in_debug_halt_q));
  endproperty
  a_protect: assert property (p_protect) else $error("protected write took effect");

endmodule
`default_nettype wire

//--- verilog/timer_event_irq_pkg.sv
// Purpose: shared constants and carriers for the timer event/irq control slice
// Assumes: APB4 slave, 32-bit data, registers one per aligned word
// Notes: printed offsets are word indices; byte address is four times the index
`default_nettype none
package timer_event_irq_pkg;
  localparam int APB_AW = 12;
  // word indices
  localparam logic [7:0] IDX_CHMODE = 8'h06;
  localparam logic [7:0] IDX_DEBUG = 8'h08;
  localparam logic [7:0] IDX_EVENT_CONTROL = 8'h0a;
  localparam logic [7:0] IDX_IRQCLR = 8'h0c;
  localparam logic [7:0] IDX_IRQSET = 8'h0d;
  // channel mode fields
  localparam int CAPSEL_LSB = 4;
  localparam int INVSEL_LSB = 0;
  // debug field
  localparam int RUN_IN_DEBUG_HALT_BIT = 0;
  // event control fields
  localparam int CHEO_LSB = 12;
  localparam int WRAPEO_BIT = 8;
  localparam int EVIN_EN_BIT = 5;
  localparam int EVIN_INV_BIT = 4;
  localparam int EVENT_ACTION_LSB = 0;
  // irq enable layout; bits 2, 6 and 7 reserved
  localparam logic [7:0] IRQ_MASK_BITS = 8'h3b;
  // reset values
  localparam logic [1:0] CHMODE_RESET = 2'h0;
  localparam logic RUN_IN_DEBUG_HALT_RESET = 1'b0;
  localparam logic [7:0] IRQEN_RESET = 8'h00;
  // event action codes
  localparam logic [2:0] ACT_OFF = 3'h0;
  localparam logic [2:0] ACT_RETRIG = 3'h1;
  localparam logic [2:0] ACT_COUNT = 3'h2;
  localparam logic [2:0] ACT_START = 3'h3;
  localparam logic [2:0] ACT_PPW = 3'h5;
  localparam logic [2:0] ACT_PWP = 3'h6;

  typedef struct packed {
    logic [1:0] chanEo;
    logic wrapEo;
    logic inEnable;
    logic inInvert;
    logic [2:0] action;
  } event_control_type;

  localparam event_control_type EVENT_CONTROL_RESET = '0;

  typedef struct packed {
    logic retrigger;
    logic countStep;
    logic startOnly;
    logic [1:0] periodCapture;
    logic [1:0] widthCapture;
  } evaction_type;
endpackage
`default_nettype wire
